/* hw/jir_pkg.sv */
package jir_pkg;

	// Tap controller states, standard sixteen-state walk
	typedef enum logic [3:0] {
		JIR_TLR, JIR_RTI,
		JIR_SEL_DR, JIR_CAP_DR, JIR_SH_DR, JIR_EX1_DR, JIR_PA_DR, JIR_EX2_DR, JIR_UPD_DR,
		JIR_SEL_IR, JIR_CAP_IR, JIR_SH_IR, JIR_EX1_IR, JIR_PA_IR, JIR_EX2_IR, JIR_UPD_IR
	} jir_state_t;

	// Decoded per-state actions handed from the controller to the data path
	typedef struct packed {
		logic tlr;
		logic cap_dr;
		logic sh_dr;
		logic upd_dr;
		logic cap_ir;
		logic sh_ir;
		logic upd_ir;
	} jir_ctl_t;

	// Instruction register layout and codes
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_IDENT = 4'h1;
	localparam logic [IR_W-1:0] IR_USER = 4'h8;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

	// Identification register; value is arbitrary, bit 0 set as the standard demands
	localparam int ID_W = 32;
	localparam logic [ID_W-1:0] ID_VALUE = 32'h0A5C_3001;

	// User data register, reachable by the user instruction
	localparam int USR_W = 8;
	localparam logic [USR_W-1:0] USR_RESET = 8'h00;

endpackage

/* hw/jir_tap_fsm.sv */
module jir_tap_fsm (
	// Link clock and reset
	input wire logic tck_i,
	input wire logic rst_i,
	// Mode select pin
	input wire logic tms_i,
	// Decoded state actions
	output jir_pkg::jir_ctl_t ctl_o
);

	jir_pkg::jir_state_t state_q, state_d;

	// Next-state walk driven by the mode select pin
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			jir_pkg::JIR_TLR: state_d = tms_i ? jir_pkg::JIR_TLR : jir_pkg::JIR_RTI;
			jir_pkg::JIR_RTI: state_d = tms_i ? jir_pkg::JIR_SEL_DR : jir_pkg::JIR_RTI;
			jir_pkg::JIR_SEL_DR: state_d = tms_i ? jir_pkg::JIR_SEL_IR : jir_pkg::JIR_CAP_DR;
			jir_pkg::JIR_CAP_DR: state_d = tms_i ? jir_pkg::JIR_EX1_DR : jir_pkg::JIR_SH_DR;
			jir_pkg::JIR_SH_DR: state_d = tms_i ? jir_pkg::JIR_EX1_DR : jir_pkg::JIR_SH_DR;
			jir_pkg::JIR_EX1_DR: state_d = tms_i ? jir_pkg::JIR_UPD_DR : jir_pkg::JIR_PA_DR;
			jir_pkg::JIR_PA_DR: state_d = tms_i ? jir_pkg::JIR_EX2_DR : jir_pkg::JIR_PA_DR;
			jir_pkg::JIR_EX2_DR: state_d = tms_i ? jir_pkg::JIR_UPD_DR : jir_pkg::JIR_SH_DR;
			jir_pkg::JIR_UPD_DR: state_d = tms_i ? jir_pkg::JIR_SEL_DR : jir_pkg::JIR_RTI;
			jir_pkg::JIR_SEL_IR: state_d = tms_i ? jir_pkg::JIR_TLR : jir_pkg::JIR_CAP_IR;
			jir_pkg::JIR_CAP_IR: state_d = tms_i ? jir_pkg::JIR_EX1_IR : jir_pkg::JIR_SH_IR;
			jir_pkg::JIR_SH_IR: state_d = tms_i ? jir_pkg::JIR_EX1_IR : jir_pkg::JIR_SH_IR;
			jir_pkg::JIR_EX1_IR: state_d = tms_i ? jir_pkg::JIR_UPD_IR : jir_pkg::JIR_PA_IR;
			jir_pkg::JIR_PA_IR: state_d = tms_i ? jir_pkg::JIR_EX2_IR : jir_pkg::JIR_PA_IR;
			jir_pkg::JIR_EX2_IR: state_d = tms_i ? jir_pkg::JIR_UPD_IR : jir_pkg::JIR_SH_IR;
			jir_pkg::JIR_UPD_IR: state_d = tms_i ? jir_pkg::JIR_SEL_DR : jir_pkg::JIR_RTI;
		endcase
	end

	// State register; reset parks the controller in test-logic-reset
	always_ff @(posedge tck_i) begin
		if (rst_i) begin
			state_q <= jir_pkg::JIR_TLR;
		end else begin
			state_q <= state_d;
		end
	end

	// Action decode, purely from the current state
	always_comb begin
		ctl_o.tlr = (state_q == jir_pkg::JIR_TLR);
		ctl_o.cap_dr = (state_q == jir_pkg::JIR_CAP_DR);
		ctl_o.sh_dr = (state_q == jir_pkg::JIR_SH_DR);
		ctl_o.upd_dr = (state_q == jir_pkg::JIR_UPD_DR);
		ctl_o.cap_ir = (state_q == jir_pkg::JIR_CAP_IR);
		ctl_o.sh_ir = (state_q == jir_pkg::JIR_SH_IR);
		ctl_o.upd_ir = (state_q == jir_pkg::JIR_UPD_IR);
	end

endmodule

/* hw/jir_top.sv */
module jir_top (
	// Core clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Scan link pins
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	// Core-side view of the scan logic
	output logic id_sel_o,
	output logic byp_sel_o,
	output logic [jir_pkg::USR_W-1:0] usr_data_o,
	output logic usr_upd_o
);

	// Reset carried into the link domain
	logic trst_s1_q, trst_s2_q;

	// Link-domain state
	jir_pkg::jir_ctl_t ctl;
	logic [jir_pkg::IR_W-1:0] ir_q, ir_d;
	logic [jir_pkg::IR_W-1:0] ir_sh_q, ir_sh_d;
	logic [jir_pkg::ID_W-1:0] id_sh_q, id_sh_d;
	logic byp_q, byp_d;
	logic [jir_pkg::USR_W-1:0] usr_sh_q, usr_sh_d;
	logic [jir_pkg::USR_W-1:0] usr_q, usr_d;
	logic upd_tgl_q, upd_tgl_d;
	// Registered decodes, the only instruction view the core domain samples
	logic id_dec_q, id_dec_d;
	logic byp_dec_q, byp_dec_d;
	logic ser_in;
	logic tdo_d, tdo_oe_d;
	logic tdo_q, tdo_oe_q;

	// Core-domain state
	logic id_s1_q, id_s2_q;
	logic byp_s1_q, byp_s2_q;
	logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic id_sel_q, byp_sel_q, usr_upd_q;
	logic [jir_pkg::USR_W-1:0] usr_data_q;
	logic id_sel_d, byp_sel_d, usr_upd_d;
	logic [jir_pkg::USR_W-1:0] usr_data_d;

	// Two stages bring the core reset onto the link clock; needs running tck to take
	always_ff @(posedge tck_i) begin
		trst_s1_q <= rst_i;
		trst_s2_q <= trst_s1_q;
	end

	// Controller walk; five tms-high clocks also reach test-logic-reset
	jir_tap_fsm u_fsm (
		.tck_i(tck_i),
		.rst_i(trst_s2_q),
		.tms_i(tms_i),
		.ctl_o(ctl)
	);

	// Serial bit entering the data path: forced high under identification
	always_comb begin
		ser_in = (ir_q == jir_pkg::IR_IDENT) ? 1'b1 : tdi_i;
	end

	// Instruction register and its shift stage
	always_comb begin
		ir_d = ir_q;
		ir_sh_d = ir_sh_q;
		if (ctl.tlr) begin
			ir_d = jir_pkg::IR_IDENT;
		end else if (ctl.cap_ir) begin
			ir_sh_d = jir_pkg::IR_CAPTURE;
		end else if (ctl.sh_ir) begin
			ir_sh_d = {tdi_i, ir_sh_q[jir_pkg::IR_W-1:1]};
		end else if (ctl.upd_ir) begin
			ir_d = ir_sh_q;
		end
		// One flop per decoded bit so the core never samples a multi-bit compare mid-change
		id_dec_d = (ir_d == jir_pkg::IR_IDENT);
		byp_dec_d = (ir_d != jir_pkg::IR_IDENT) && (ir_d != jir_pkg::IR_USER);
	end

	always_ff @(posedge tck_i) begin
		if (trst_s2_q) begin
			ir_q <= jir_pkg::IR_IDENT;
			ir_sh_q <= jir_pkg::IR_CAPTURE;
			id_dec_q <= 1'b1;
			byp_dec_q <= 1'b0;
		end else begin
			ir_q <= ir_d;
			ir_sh_q <= ir_sh_d;
			id_dec_q <= id_dec_d;
			byp_dec_q <= byp_dec_d;
		end
	end

	// Data registers; only the one selected by the instruction moves
	always_comb begin
		id_sh_d = id_sh_q;
		byp_d = byp_q;
		usr_sh_d = usr_sh_q;
		usr_d = usr_q;
		upd_tgl_d = upd_tgl_q;
		unique case (ir_q)
			jir_pkg::IR_IDENT: begin
				// Capture reloads the fixed value; update has nothing to write
				if (ctl.cap_dr) begin
					id_sh_d = jir_pkg::ID_VALUE;
				end else if (ctl.sh_dr) begin
					id_sh_d = {ser_in, id_sh_q[jir_pkg::ID_W-1:1]};
				end
			end
			jir_pkg::IR_USER: begin
				if (ctl.cap_dr) begin
					usr_sh_d = usr_q;
				end else if (ctl.sh_dr) begin
					usr_sh_d = {ser_in, usr_sh_q[jir_pkg::USR_W-1:1]};
				end else if (ctl.upd_dr) begin
					usr_d = usr_sh_q;
					upd_tgl_d = ~upd_tgl_q;
				end
			end
			default: begin
				// Bypass and every unassigned code use the one-bit path
				if (ctl.cap_dr) begin
					byp_d = 1'b0;
				end else if (ctl.sh_dr) begin
					byp_d = ser_in;
				end
			end
		endcase
	end

	always_ff @(posedge tck_i) begin
		if (trst_s2_q) begin
			id_sh_q <= jir_pkg::ID_VALUE;
			byp_q <= 1'b0;
			usr_sh_q <= jir_pkg::USR_RESET;
			usr_q <= jir_pkg::USR_RESET;
			upd_tgl_q <= 1'b0;
		end else begin
			id_sh_q <= id_sh_d;
			byp_q <= byp_d;
			usr_sh_q <= usr_sh_d;
			usr_q <= usr_d;
			upd_tgl_q <= upd_tgl_d;
		end
	end

	// Output mux; driven only while shifting, else released
	always_comb begin
		tdo_oe_d = ctl.sh_ir | ctl.sh_dr;
		tdo_d = 1'b0;
		if (ctl.sh_ir) begin
			tdo_d = ir_sh_q[0];
		end else if (ctl.sh_dr) begin
			unique case (ir_q)
				jir_pkg::IR_IDENT: tdo_d = id_sh_q[0];
				jir_pkg::IR_USER: tdo_d = usr_sh_q[0];
				default: tdo_d = byp_q;
			endcase
		end
	end

	// Falling edge launch gives the next device a full half period of setup
	always_ff @(negedge tck_i) begin
		if (trst_s2_q) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
		end
	end

	assign tdo_o = tdo_q;
	assign tdo_oe_o = tdo_oe_q;

	// Level crossings of the instruction decode and the update toggle into the core domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_s1_q <= 1'b0;
			id_s2_q <= 1'b0;
			byp_s1_q <= 1'b0;
			byp_s2_q <= 1'b0;
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			id_s1_q <= id_dec_q;
			id_s2_q <= id_s1_q;
			byp_s1_q <= byp_dec_q;
			byp_s2_q <= byp_s1_q;
			tgl_s1_q <= upd_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	// Toggle edge marks a user update; usr_q is stable long before the toggle lands
	always_comb begin
		id_sel_d = id_s2_q;
		byp_sel_d = byp_s2_q;
		usr_upd_d = tgl_s2_q ^ tgl_s3_q;
		usr_data_d = usr_data_q;
		if (tgl_s2_q ^ tgl_s3_q) begin
			usr_data_d = usr_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_sel_q <= 1'b0;
			byp_sel_q <= 1'b0;
			usr_upd_q <= 1'b0;
			usr_data_q <= jir_pkg::USR_RESET;
		end else begin
			id_sel_q <= id_sel_d;
			byp_sel_q <= byp_sel_d;
			usr_upd_q <= usr_upd_d;
			usr_data_q <= usr_data_d;
		end
	end

	assign id_sel_o = id_sel_q;
	assign byp_sel_o = byp_sel_q;
	assign usr_upd_o = usr_upd_q;
	assign usr_data_o = usr_data_q;

endmodule

/* verification/jir_chain_model.sv */
module jir_chain_model (
	// Scan link toward the device
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	input wire logic tdo_i,
	input wire logic tdo_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// Link clock stands low between frames
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end
	// One link cycle; tdo is taken just before the rising edge
	task automatic step(input logic ms, input logic di, output logic dq);
		tms_o = ms;
		tdi_o = di;
		// A released line reads inverted, so sampling outside a shift cannot pass
		#15 dq = tdo_oe_i ? tdo_i : ~tdo_i;
		tck_o = 1'b1;
		#15 tck_o = 1'b0;
	endtask
	// Five ones reach test-logic-reset from anywhere, then park in idle
	task automatic tlr();
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b1, q);
	endtask
	// Idle link cycles with tms low; keeps the link clock running through a reset
	task automatic idle(input int n);
		logic q;
		repeat (n) step(1'b0, 1'b0, q);
	endtask
	// Scan n bits LSB first from idle; tdi is inverted once released
	task automatic scan(input logic ir, input int n, input logic [39:0] din,
		output logic [39:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~din[n-1], q);
		step(1'b0, din[n-1], q);
	endtask
endmodule

/* verification/jir_checker.sv */
module jir_checker (
	// Core side
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic id_sel_o,
	input wire logic byp_sel_o,
	input wire logic [jir_pkg::USR_W-1:0] usr_data_o,
	input wire logic usr_upd_o,
	// Scan link
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Bits shifted so far; wraps past 63, so long scans are not judged
	logic [5:0] cnt_q;
	always_ff @(posedge tck_i) cnt_q <= tdo_oe_o ? cnt_q + 6'h01 : 6'h00;
	sequence s_pulse;
		usr_upd_o ##1 !usr_upd_o;
	endsequence
	property p_upd_pulse;
		@(posedge clk_i) disable iff (rst_i) $rose(usr_upd_o) |-> s_pulse;
	endproperty
	property p_data_chg;
		@(posedge clk_i) disable iff (rst_i) $changed(usr_data_o) |-> usr_upd_o;
	endproperty
	property p_sel_excl;
		@(posedge clk_i) disable iff (rst_i) !(id_sel_o && byp_sel_o);
	endproperty
	property p_upd_user;
		@(posedge clk_i) disable iff (rst_i) usr_upd_o |-> !id_sel_o && !byp_sel_o;
	endproperty
	property p_rst_val;
		@(posedge clk_i) disable iff (rst_i)
			$fell(rst_i) |-> usr_data_o == jir_pkg::USR_RESET && !usr_upd_o;
	endproperty
	property p_id_rst;
		@(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> ##[1:8] id_sel_o;
	endproperty
	property p_oe_exit;
		@(posedge tck_i) disable iff (rst_i) tdo_oe_o && tms_i |=> !tdo_oe_o;
	endproperty
	property p_id_ones;
		@(posedge tck_i) disable iff (rst_i)
			id_sel_o && tdo_oe_o && cnt_q > 6'h1F |-> tdo_o;
	endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");
	a_data_chg: assert property (p_data_chg) else $error("data moved unannounced");
	a_sel_excl: assert property (p_sel_excl) else $error("two paths selected");
	a_upd_user: assert property (p_upd_user) else $error("update outside user");
	a_rst_val: assert property (p_rst_val) else $error("bad reset value");
	a_id_rst: assert property (p_id_rst) else $error("no id after reset");
	a_oe_exit: assert property (p_oe_exit) else $error("drive kept after shift");
	a_id_ones: assert property (p_id_ones) else $error("id shift let a zero out");
endmodule

/* verification/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic tck, tms, tdi, tdo, tdo_oe, id_sel, byp_sel, usr_upd;
	logic [jir_pkg::USR_W-1:0] usr_data;
	logic [39:0] r;
	int error_cnt = 0;
	int check_count = 0;
	always #12.5 clk_i = ~clk_i;
	jir_chain_model ctl_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
		.tdo_oe_i(tdo_oe));
	jir_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_o(tdo_oe), .id_sel_o(id_sel), .byp_sel_o(byp_sel),
		.usr_data_o(usr_data), .usr_upd_o(usr_upd));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Default path after reset, read twice: upstream zeros come out as ones
	task automatic t_ident();
		cyc(5);
		chk({id_sel, byp_sel}, 2'b10);
		repeat (2) begin
			ctl_u.scan(1'b0, 40, 40'h0, r);
			chk(r[31:0], jir_pkg::ID_VALUE);
			chk(r[39:32], 8'hFF);
		end
	endtask
	// Bypass gives a one-bit delay; five ones bring identification back
	task automatic t_bypass();
		ctl_u.scan(1'b1, 4, jir_pkg::IR_BYPASS, r);
		chk(r[3:0], jir_pkg::IR_CAPTURE);
		cyc(5);
		chk({id_sel, byp_sel}, 2'b01);
		ctl_u.scan(1'b0, 9, 40'h0A5, r);
		chk(r[8:0], 9'h14A);
		ctl_u.tlr();
		cyc(5);
		chk({id_sel, byp_sel}, 2'b10);
	endtask
	// Back-to-back user updates each land with a single pulse
	task automatic t_user();
		int w;
		ctl_u.scan(1'b1, 4, jir_pkg::IR_USER, r);
		cyc(5);
		chk({id_sel, byp_sel}, 2'b00);
		for (int k = 0; k < 2; k++) begin
			ctl_u.scan(1'b0, 8, k ? 40'hC3 : 40'h3C, r);
			w = 0;
			while (usr_upd !== 1'b1 && w < 20) begin
				cyc(1);
				w++;
			end
			chk(usr_data, k ? 8'hC3 : 8'h3C);
			cyc(1);
			chk(usr_upd, 1'b0);
		end
	endtask
	// Mid-run reset on the user path; link clock runs so the link side sees it
	task automatic t_reset();
		rst_i = 1'b1;
		fork
			cyc(10);
			ctl_u.idle(8);
		join
		rst_i = 1'b0;
		chk(usr_data, jir_pkg::USR_RESET);
		ctl_u.idle(3);
		cyc(5);
		chk({id_sel, byp_sel}, 2'b10);
	endtask
	// Watchdog well beyond the expected few microseconds
	initial begin
		#50000;
		error_cnt++;
		test_done();
	end
	initial begin
		fork
			cyc(10);
			ctl_u.tlr();
		join
		rst_i = 1'b0;
		ctl_u.tlr();
		t_ident();
		t_bypass();
		t_user();
		t_reset();
		test_done();
	end
endmodule
bind jir_top jir_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .id_sel_o(id_sel_o),
	.byp_sel_o(byp_sel_o), .usr_data_o(usr_data_o), .usr_upd_o(usr_upd_o), .tck_i(tck_i),
	.tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o));
